// ===== include/sleep_gate_pkg.sv
package sleep_gate_pkg;

  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 12;
  localparam int NUM_UNITS  = 12;
  localparam int UNIT_IDX_W = 4;
  localparam int EV_W       = 2;
  localparam int FAULT_CNT_W = 16;

  // System control block base; the address port carries the offset only
  localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;

  localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS  = 12'h114;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS  = 12'h180;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS    = 12'h184;
  localparam logic [ADDR_W-1:0] ACTIVE_GATE_OFS = 12'h188;
  localparam logic [ADDR_W-1:0] FAULT_INFO_OFS  = 12'h18C;

  localparam logic [DATA_W-1:0] SLEEP_GATE_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] SLEEP_GATE_WMASK = 32'h030F5033;
  localparam logic [EV_W-1:0]   IRQ_RESET        = 2'h0;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_RESET = 16'h0000;

  localparam int COMPARATOR_B_BIT = 25;
  localparam int COMPARATOR_A_BIT = 24;
  localparam int GP_COUNTER_D_BIT = 19;
  localparam int GP_COUNTER_C_BIT = 18;
  localparam int GP_COUNTER_B_BIT = 17;
  localparam int GP_COUNTER_A_BIT = 16;
  localparam int TWO_WIRE_B_BIT   = 14;
  localparam int TWO_WIRE_A_BIT   = 12;
  localparam int SYNC_SERIAL_B_BIT = 5;
  localparam int SYNC_SERIAL_A_BIT = 4;
  localparam int ASYNC_SERIAL_B_BIT = 1;
  localparam int ASYNC_SERIAL_A_BIT = 0;

  // Unit index to register bit position
  localparam int UNIT_BIT [NUM_UNITS] = '{
    ASYNC_SERIAL_A_BIT, ASYNC_SERIAL_B_BIT,
    SYNC_SERIAL_A_BIT,  SYNC_SERIAL_B_BIT,
    TWO_WIRE_A_BIT,     TWO_WIRE_B_BIT,
    GP_COUNTER_A_BIT,   GP_COUNTER_B_BIT,
    GP_COUNTER_C_BIT,   GP_COUNTER_D_BIT,
    COMPARATOR_A_BIT,   COMPARATOR_B_BIT
  };

  localparam int EV_FAULT       = 0;
  localparam int EV_GATE_CHANGE = 1;

  localparam int FAULT_UNIT_LSB  = 0;
  localparam int FAULT_WRITE_BIT = 8;
  localparam int FAULT_CNT_LSB   = 16;

  typedef enum logic [2:0] {
    PM_RUN   = 3'b001,
    PM_SLEEP = 3'b010,
    PM_DEEP  = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [UNIT_IDX_W-1:0] unit;
  } unit_access_t;

endpackage

// ===== verilog/unit_clock_gate.sv
`timescale 1ns/1ps
module unit_clock_gate (
  // Clock
  input  wire logic clk,
  // Enable from the clock domain
  input  wire logic enable,
  // Gated clock
  output logic      gclk
);
  logic en_latched;

  // Latch open only while clk is low, so the gate never cuts a high phase
  always_latch begin
    if (!clk) begin
      en_latched = enable;
    end
  end

  assign gclk = clk & en_latched;
endmodule

// ===== verilog/access_fault_check.sv
`timescale 1ns/1ps
module access_fault_check
  import sleep_gate_pkg::*;
#(
  parameter int UNITS = NUM_UNITS
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  // Access and clock state
  input  wire sleep_gate_pkg::unit_access_t access,
  input  wire logic [UNITS-1:0]            clocked,
  // Fault result
  output logic                             fault,
  output logic [UNIT_IDX_W-1:0]            fault_unit,
  output logic                             fault_write
);
  logic hit_off;

  assign hit_off = access.valid &&
                   (32'(access.unit) < 32'(UNITS)) &&
                   !clocked[access.unit];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault       <= 1'b0;
      fault_unit  <= '0;
      fault_write <= 1'b0;
    end else if (clk_en) begin
      fault <= hit_off;
      if (hit_off) begin
        fault_unit  <= access.unit;
        fault_write <= access.write;
      end
    end
  end
endmodule

// ===== verilog/sleep_mode_clock_gating.sv
`timescale 1ns/1ps
module sleep_mode_clock_gating
  import sleep_gate_pkg::*;
#(
  parameter int UNITS = NUM_UNITS
) (
  // Clock, reset and freeze
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // Register port
  input  wire sleep_gate_pkg::reg_req_t      req,
  output logic [DATA_W-1:0]                  rdata,
  // Companion gating state from the clock controller
  input  wire sleep_gate_pkg::power_mode_t   power_mode,
  input  wire logic                          auto_clock_gating,
  input  wire logic [DATA_W-1:0]             run_clock_gate_1,
  input  wire logic [DATA_W-1:0]             deep_sleep_clock_gate_1,
  // Peripheral access check
  input  wire sleep_gate_pkg::unit_access_t  access,
  output logic                               bus_fault,
  // Unit clocks
  output logic [UNITS-1:0]                   unit_clk_en,
  output logic [UNITS-1:0]                   unit_clk,
  // Interrupt
  output logic                               irq
);
  import sleep_gate_pkg::*;

  logic [DATA_W-1:0]      sleep_clock_gate_1;
  logic [EV_W-1:0]        irq_status;
  logic [EV_W-1:0]        irq_mask;
  logic [EV_W-1:0]        next_status;
  logic [EV_W-1:0]        next_mask;
  logic [EV_W-1:0]        events;
  logic [DATA_W-1:0]      selected_gate;
  logic [UNITS-1:0]       next_clk_en;
  logic [DATA_W-1:0]      active_word;
  logic [FAULT_CNT_W-1:0] fault_count;
  logic [UNIT_IDX_W-1:0]  fault_unit;
  logic                   fault_write;
  logic                   fault_pulse;
  logic                   wr_sleep;
  logic                   wr_status;
  logic                   wr_mask;
  logic [DATA_W-1:0]      next_rdata;

  assign wr_sleep  = req.wr && (req.addr == SLEEP_GATE_OFS);
  assign wr_status = req.wr && (req.addr == IRQ_STATUS_OFS);
  assign wr_mask   = req.wr && (req.addr == IRQ_MASK_OFS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_clock_gate_1 <= SLEEP_GATE_RESET;
    end else if (clk_en && wr_sleep) begin
      sleep_clock_gate_1 <= req.wdata & SLEEP_GATE_WMASK;
    end
  end

  always_comb begin
    unique case (power_mode)
      PM_RUN: begin
        selected_gate = run_clock_gate_1;
      end
      PM_SLEEP: begin
        selected_gate = auto_clock_gating ? sleep_clock_gate_1
                                          : run_clock_gate_1;
      end
      PM_DEEP: begin
        selected_gate = auto_clock_gating ? deep_sleep_clock_gate_1
                                          : run_clock_gate_1;
      end
      default: begin
        selected_gate = run_clock_gate_1;
      end
    endcase
  end

  always_comb begin
    for (int i = 0; i < UNITS; i++) begin
      next_clk_en[i] = selected_gate[UNIT_BIT[i]];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unit_clk_en <= '0;
    end else if (clk_en) begin
      unit_clk_en <= next_clk_en;
    end
  end

  for (genvar g = 0; g < UNITS; g++) begin : gen_gate
    unit_clock_gate u_gate (
      .clk    (clk),
      .enable (unit_clk_en[g]),
      .gclk   (unit_clk[g])
    );
  end

  access_fault_check #(
    .UNITS (UNITS)
  ) u_fault (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .access      (access),
    .clocked     (unit_clk_en),
    .fault       (fault_pulse),
    .fault_unit  (fault_unit),
    .fault_write (fault_write)
  );

  assign bus_fault = fault_pulse;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_count <= FAULT_CNT_RESET;
    end else if (clk_en && fault_pulse) begin
      fault_count <= fault_count + 16'h0001;
    end
  end

  // Active gate word in register layout
  always_comb begin
    active_word = '0;
    for (int i = 0; i < UNITS; i++) begin
      active_word[UNIT_BIT[i]] = unit_clk_en[i];
    end
  end

  // Events: fault, and any change of the applied gates
  always_comb begin
    events                 = '0;
    events[EV_FAULT]       = fault_pulse;
    events[EV_GATE_CHANGE] = (next_clk_en != unit_clk_en);
  end

  // Set wins over write-one clear
  always_comb begin
    next_status = irq_status;
    if (wr_status) begin
      next_status = irq_status & ~req.wdata[EV_W-1:0];
    end
    next_status = next_status | events;
    next_mask = wr_mask ? req.wdata[EV_W-1:0] : irq_mask;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= IRQ_RESET;
      irq_mask   <= IRQ_RESET;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= next_status;
      irq_mask   <= next_mask;
      irq        <= |(next_status & next_mask);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    unique case (req.addr)
      SLEEP_GATE_OFS: begin
        next_rdata = sleep_clock_gate_1;
      end
      IRQ_STATUS_OFS: begin
        next_rdata[EV_W-1:0] = irq_status;
      end
      IRQ_MASK_OFS: begin
        next_rdata[EV_W-1:0] = irq_mask;
      end
      ACTIVE_GATE_OFS: begin
        next_rdata = active_word;
      end
      FAULT_INFO_OFS: begin
        next_rdata[FAULT_UNIT_LSB +: UNIT_IDX_W] = fault_unit;
        next_rdata[FAULT_WRITE_BIT]              = fault_write;
        next_rdata[FAULT_CNT_LSB +: FAULT_CNT_W] = fault_count;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= req.rd ? next_rdata : '0;
    end
  end
endmodule

// ===== bench/unit_model.sv
`timescale 1ns/1ps
module unit_model
  import sleep_gate_pkg::*;
(
  // Reset and gated clocks
  input  wire logic                 sys_rst,
  input  wire logic [NUM_UNITS-1:0] unit_clk,
  // Flips once per received rising edge
  output logic [NUM_UNITS-1:0]      tog
);
  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    always_ff @(posedge unit_clk[g] or posedge sys_rst) begin
      if (sys_rst) begin
        tog[g] <= 1'h0;
      end else begin
        tog[g] <= ~tog[g];
      end
    end
  end
endmodule

// ===== bench/sleep_gate_asserts.sv
`timescale 1ns/1ps
module sleep_gate_asserts
  import sleep_gate_pkg::*;
#(parameter int UNITS = NUM_UNITS) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         clk_en,
  // Register port
  input wire sleep_gate_pkg::reg_req_t     req,
  input wire logic [DATA_W-1:0]            rdata,
  // Mode and companion gates
  input wire sleep_gate_pkg::power_mode_t  power_mode,
  input wire logic                         auto_clock_gating,
  input wire logic [DATA_W-1:0]            run_clock_gate_1,
  input wire logic [DATA_W-1:0]            deep_sleep_clock_gate_1,
  // Access and clocks
  input wire sleep_gate_pkg::unit_access_t access,
  input wire logic                         bus_fault,
  input wire logic [UNITS-1:0]             unit_clk_en,
  input wire logic [UNITS-1:0]             unit_clk
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  function automatic logic [UNITS-1:0] pick(logic [DATA_W-1:0] v);
    return {v[25:24], v[19:16], v[14], v[12], v[5:4], v[1:0]};
  endfunction
  sequence s_bad;
    clk_en && access.valid && access.unit < 4'hC && !unit_clk_en[access.unit];
  endsequence
  property p_fault; s_bad |=> bus_fault; endproperty
  a_fault: assert property (p_fault) else $error("fault missing");
  property p_nofault; clk_en && !(access.valid && access.unit < 4'hC
    && !unit_clk_en[access.unit]) |=> !bus_fault; endproperty
  a_nofault: assert property (p_nofault) else $error("stray fault");
  property p_rd_idle; clk_en && !req.rd |=> rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rsvd; clk_en && req.rd && req.addr == 12'h114
    |=> (rdata & 32'hFCF0AFCC) == '0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_run; clk_en && power_mode == PM_RUN
    |=> unit_clk_en == pick($past(run_clock_gate_1)); endproperty
  a_run: assert property (p_run) else $error("run gates wrong");
  property p_noauto; clk_en && power_mode == PM_SLEEP && !auto_clock_gating
    |=> unit_clk_en == pick($past(run_clock_gate_1)); endproperty
  a_noauto: assert property (p_noauto) else $error("sleep ignored auto");
  property p_deep; clk_en && power_mode == PM_DEEP && auto_clock_gating
    |=> unit_clk_en == pick($past(deep_sleep_clock_gate_1)); endproperty
  a_deep: assert property (p_deep) else $error("deep gates wrong");
  property p_gclk; @(negedge clk) disable iff (sys_rst)
    unit_clk == $past(unit_clk_en); endproperty
  a_gclk: assert property (p_gclk) else $error("gated clock wrong");
endmodule
bind sleep_mode_clock_gating sleep_gate_asserts #(.UNITS(UNITS)) sleep_gate_asserts_i (
  .clk                     (clk),
  .sys_rst                 (sys_rst),
  .clk_en                  (clk_en),
  .req                     (req),
  .rdata                   (rdata),
  .power_mode              (power_mode),
  .auto_clock_gating       (auto_clock_gating),
  .run_clock_gate_1        (run_clock_gate_1),
  .deep_sleep_clock_gate_1 (deep_sleep_clock_gate_1),
  .access                  (access),
  .bus_fault               (bus_fault),
  .unit_clk_en             (unit_clk_en),
  .unit_clk                (unit_clk)
);

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  import sleep_gate_pkg::*;
  logic                 clk;
  logic                 sys_rst;
  logic                 clk_en;
  reg_req_t             req;
  logic [DATA_W-1:0]    rdata;
  power_mode_t          power_mode;
  logic                 auto_clock_gating;
  logic [DATA_W-1:0]    run_clock_gate_1;
  logic [DATA_W-1:0]    deep_sleep_clock_gate_1;
  unit_access_t         access;
  logic                 bus_fault;
  logic [NUM_UNITS-1:0] unit_clk_en;
  logic [NUM_UNITS-1:0] unit_clk;
  logic                 irq;
  logic [NUM_UNITS-1:0] tog;
  logic [NUM_UNITS-1:0] snap;
  logic [DATA_W-1:0]    last;
  int                   mismatches;
  int                   checks;
  int                   bits [NUM_UNITS] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};
  // Last entry is an unused mode code, which must act as run
  power_mode_t          modes [7] = '{PM_SLEEP, PM_SLEEP, PM_RUN, PM_DEEP, PM_DEEP, PM_SLEEP,
                                      power_mode_t'(3'h0)};
  logic [6:0]           autos = 7'h6E;
  logic [11:0]          want [7] = '{12'h001, 12'h800, 12'h001, 12'h040, 12'h001, 12'h800,
                                     12'h001};

  sleep_mode_clock_gating sleep_mode_clock_gating_i (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .clk_en                  (clk_en),
    .req                     (req),
    .rdata                   (rdata),
    .power_mode              (power_mode),
    .auto_clock_gating       (auto_clock_gating),
    .run_clock_gate_1        (run_clock_gate_1),
    .deep_sleep_clock_gate_1 (deep_sleep_clock_gate_1),
    .access                  (access),
    .bus_fault               (bus_fault),
    .unit_clk_en             (unit_clk_en),
    .unit_clk                (unit_clk),
    .irq                     (irq)
  );
  unit_model unit_model_i (
    .sys_rst  (sys_rst),
    .unit_clk (unit_clk),
    .tog      (tog)
  );

  initial clk = 1'h0;
  always #5 clk = ~clk;

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    req <= '{a, d, 1'h1, 1'h0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp, string what);
    req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    last = rdata;
    chk(what, exp, last);
  endtask
  task automatic acc(logic [3:0] u, logic w, logic exp);
    access <= '{1'h1, w, u};
    @(posedge clk);
    access <= '0;
    @(posedge clk);
    chk("bus_fault", {31'h0, exp}, {31'h0, bus_fault});
  endtask
  // Checks which units saw an odd number of clock edges over three cycles
  task automatic live(logic [NUM_UNITS-1:0] exp);
    #1 snap = tog;
    repeat (3) @(posedge clk);
    #1 chk("ticks", {20'h0, exp}, {20'h0, snap ^ tog});
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'h1;
    clk_en = 1'h1;
    req = '0;
    access = '0;
    power_mode = PM_SLEEP;
    auto_clock_gating = 1'h1;
    run_clock_gate_1 = 32'h00000001;
    deep_sleep_clock_gate_1 = 32'h00010000;
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    rd(12'h114, 32'h0, "gate_reg");
    chk("unit_clk_en", 32'h0, {20'h0, unit_clk_en});
    rd(12'h180, 32'h0, "status");
    $display("test reset done");
    wr(12'h114, 32'hFFFFFFFF);
    rd(12'h114, 32'h030F5033, "gate_reg");
    wr(12'h118, 32'h0);
    rd(12'h118, 32'h0, "unmapped");
    rd(12'h114, 32'h030F5033, "gate_reg");
    wr(12'h114, last & 32'hFFFFFFFE);
    rd(12'h114, 32'h030F5032, "gate_reg");
    $display("test register map done");
    for (int i = 0; i < NUM_UNITS; i++) begin
      wr(12'h114, 32'h1 << bits[i]);
      @(posedge clk);
      chk("unit_clk_en", 32'h1 << i, {20'h0, unit_clk_en});
      live(12'h1 << i);
    end
    rd(12'h188, 32'h02000000, "active_gates");
    $display("test unit gates done");
    wr(12'h184, 32'h0);
    acc(4'h3, 1'h0, 1'h1);
    chk("irq", 32'h0, {31'h0, irq});
    rd(12'h180, 32'h3, "status");
    wr(12'h184, 32'h1);
    @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h184, 32'h1, "mask");
    acc(4'h3, 1'h1, 1'h1);
    acc(4'hB, 1'h0, 1'h0);
    rd(12'h18C, 32'h00020103, "fault_info");
    wr(12'h180, 32'h3);
    @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(12'h180, 32'h0, "status");
    $display("test faults done");
    for (int k = 0; k < 7; k++) begin
      power_mode <= modes[k];
      auto_clock_gating <= autos[k];
      repeat (2) @(posedge clk);
      chk("mode_gates", {20'h0, want[k]}, {20'h0, unit_clk_en});
    end
    $display("test power modes done");
    // Frozen write must not land
    clk_en <= 1'h0;
    wr(12'h114, 32'h00000001);
    clk_en <= 1'h1;
    rd(12'h114, 32'h02000000, "frozen_reg");
    $display("test freeze done");
    power_mode <= PM_SLEEP;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    chk("unit_clk_en", 32'h0, {20'h0, unit_clk_en});
    rd(12'h114, 32'h0, "gate_reg");
    rd(12'h180, 32'h0, "status");
    rd(12'h184, 32'h0, "mask");
    rd(12'h18C, 32'h0, "fault_info");
    $display("test second reset done");
    report_and_stop();
  end
endmodule
